// ---- design/lifetime_timer.sv ----
`timescale 1ns/10ps
// Functional notes
// [R1] Free-running wraps to max or minimum
// [R2] Periodic restarts from the load value
// [R3] Count readable any time, undisturbed
// [R4] Control write with enable starts timer
// [R5] Interrupt at zero or full scale
// [R6] Any clear-register write drops interrupt; code keeps it set if a terminal step falls in the same cycle
// [R7] Five-bit code selects capture source
// [R8] Software picks 32 kHz, divide 256
// [R9] Time-of-day fields with zero gaps
// [R10] Format field 5:4 selects layout
// [R11] 48-bit up or 16-bit up/down
// [R12] Four selectable clock sources
// [R13] 48-bit counts up from zero
// [R14] 16-bit load value enters the counter
// [R15] Capture copies count, count continues
// [R16] Reload on overflow and on clear
// [R17] Capture enable 17, event 16:12
// [R18] Clock select field at 10:9
// [R19] Prescaler field at 3:0
// [R20] Direction, enable, periodic, width bits
// [R21] Capture on rising edge only
// [R22] Interrupt sticky; set beats clear
module lifetime_timer
  import lifetime_timer_pkg::*;
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 RESETN,
  input  wire logic                 CLK_EN,
  input  wire logic [7:0]           ADDR,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic      [31:0]          RDATA,
  input  wire logic [EVT_COUNT-1:1] IRQ_SOURCES,
  input  wire logic                 OSC32K_IN,
  input  wire logic                 XTAL32K_IN,
  input  wire logic                 UNDIVIDED_PLL_CLOCK,
  output logic                      TIMER_IRQ
);

  logic [CONTROL_W-1:0] control_r;   // Control register
  logic [31:0]          load_r;      // Load value
  logic [47:0]          count_r;     // Running count
  logic [15:0]          capture_r;   // Captured count
  logic                 src_prev_r;  // Last sampled capture source
  logic                 tick;        // Prescaled count step
  logic [EVT_COUNT-1:0] src_vec;     // All capture sources
  logic                 src_sel;     // Chosen capture source
  logic                 cap_fire;    // Capture event this cycle
  logic                 wr_load;     // Write decodes
  logic                 wr_ctrl;
  logic                 wr_clear;
  logic                 at_term;     // Count sits at zero or full scale
  logic                 term_evt;    // Terminal step taken this cycle
  logic [47:0]          wrap_val;    // Value after a terminal step
  logic [47:0]          reload_val;  // Value on a clear write
  logic [47:0]          step_val;    // Value after a normal step

  // Control field views
  logic [1:0] fmt;
  logic       periodic;
  logic       enabled;
  logic       count_up;
  logic       cap_en;
  logic [4:0] evt_code;

  assign fmt      = control_r[FORMAT_LSB +: 2];     // [R10]
  assign periodic = control_r[PERIODIC_BIT];        // [R20]
  assign enabled  = control_r[ENABLE_BIT];
  assign count_up = control_r[COUNT_UP_BIT];
  assign cap_en   = control_r[CAP_EN_BIT];          // [R17]
  assign evt_code = control_r[EVENT_LSB +: 5];

  function automatic logic is16(input logic [1:0] f);
    return (f == FMT_BIN16) || (f == FMT_ALT16);
  endfunction : is16

  // Time-of-day increment: 1/128, seconds, minutes, then hours
  function automatic logic [31:0] hms_step(input logic [31:0] t);
    logic [31:0] r;
    r = t & HMS_MASK;  // [R9]
    if (r[6:0] != HMS_SUB_MAX) begin
      r[6:0] = r[6:0] + 7'h01;
    end else begin
      r[6:0] = 7'h00;
      if (r[13:8] != HMS_SEC_MAX) begin
        r[13:8] = r[13:8] + 6'h01;
      end else begin
        r[13:8] = 6'h00;
        if (r[21:16] != HMS_SEC_MAX) begin
          r[21:16] = r[21:16] + 6'h01;
        end else begin
          r[21:16] = 6'h00;
          r[31:24] = r[31:24] + 8'h01;
        end
      end
    end
    return r;
  endfunction : hms_step

  // Restart value after a terminal step, also used when starting
  function automatic logic [47:0] wrap_value(input logic [1:0] f, input logic per,
                                             input logic up, input logic [31:0] ld);
    if (is16(f)) begin
      if (per)
        return {32'h00000000, ld[15:0]};     // [R2]
      else if (up)
        return 48'h000000000000;             // [R1]
      else
        return 48'h00000000FFFF;             // [R1]
    end else if (f == FMT_HMS) begin
      return per ? {16'h0000, ld & HMS_MASK} : 48'h000000000000;
    end else begin
      return 48'h000000000000;               // [R13]
    end
  endfunction : wrap_value

  // Bus decode; every register access is frozen with the clock enable
  always_comb begin
    wr_load  = 1'b0;
    wr_ctrl  = 1'b0;
    wr_clear = 1'b0;
    if (CLK_EN && WR) begin
      if (ADDR == LOAD_OFS)
        wr_load = 1'b1;
      else if (ADDR == CONTROL_OFS)
        wr_ctrl = 1'b1;
      else if (ADDR == CLEAR_OFS)
        wr_clear = 1'b1;
    end
  end

  // Count arithmetic
  always_comb begin
    wrap_val   = wrap_value(fmt, periodic, count_up, load_r);
    reload_val = (fmt == FMT_BIN48) ? 48'h000000000000 :
                 (fmt == FMT_HMS) ? {16'h0000, load_r & HMS_MASK} :
                 {32'h00000000, load_r[15:0]};  // [R14] [R16]
    if (is16(fmt)) begin  // [R11]
      at_term  = count_up ? (count_r[15:0] == 16'hFFFF) : (count_r[15:0] == 16'h0000);
      step_val = {32'h00000000, count_up ? count_r[15:0] + 16'h0001
                                         : count_r[15:0] - 16'h0001};
    end else if (fmt == FMT_HMS) begin
      at_term  = (count_r[31:0] == HMS_FULL);
      step_val = {16'h0000, hms_step(count_r[31:0])};
    end else begin
      at_term  = (count_r == 48'hFFFFFFFFFFFF);
      step_val = count_r + 48'h000000000001;  // [R13]
    end
    term_evt = CLK_EN && enabled && tick && at_term;
  end

  // Prescaled source-clock steps
  lifetime_tick_gen u_tick (
    .clk      (CORE_CLK),
    .rst_n    (RESETN),
    .ce       (CLK_EN),
    .run      (enabled),
    .clk_sel  (control_r[CLK_SEL_LSB +: 2]),
    .prescale (control_r[PRESCALE_LSB +: 4]),
    .osc_in   (OSC32K_IN),
    .xtal_in  (XTAL32K_IN),
    .undiv_in (UNDIVIDED_PLL_CLOCK),
    .tick     (tick)
  );

  // Control register; bits 31:18 are not stored and read as zero, reserved bit 11 is stored and read back
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      control_r <= CONTROL_RST;
    else if (wr_ctrl)
      control_r <= WDATA[CONTROL_W-1:0];  // [R4] [R20]
  end

  // Load register; wide enough for the time-of-day layout
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      load_r <= LOAD_RST;
    else if (wr_load)
      load_r <= WDATA;
  end

  // Counter: writes first, then steps; reads never touch it
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_r <= COUNT_RST;
    end else if (CLK_EN) begin
      if (wr_ctrl && WDATA[ENABLE_BIT] && !enabled) begin
        // Starting: seed from the freshly written settings
        count_r <= wrap_value(WDATA[FORMAT_LSB +: 2], WDATA[PERIODIC_BIT],
                              WDATA[COUNT_UP_BIT], load_r);  // [R4]
      end else if (wr_clear) begin
        count_r <= reload_val;  // [R16]
      end else if (wr_load && is16(fmt)) begin
        count_r <= {32'h00000000, WDATA[15:0]};  // [R14]
      end else if (term_evt) begin
        count_r <= wrap_val;  // [R1] [R2] [R16]
      end else if (enabled && tick) begin
        count_r <= step_val;
      end
    end
  end

  // Interrupt flag: a terminal step in the clear cycle keeps it set
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      TIMER_IRQ <= 1'b0;
    else if (term_evt)
      TIMER_IRQ <= 1'b1;  // [R5] [R22]
    else if (wr_clear)
      TIMER_IRQ <= 1'b0;  // [R6]
  end

  // Capture source selection; unused codes select nothing
  always_comb begin
    src_vec = {IRQ_SOURCES, TIMER_IRQ};  // Code 0 is this timer
    if (evt_code < 5'(EVT_COUNT))
      src_sel = src_vec[evt_code];  // [R7]
    else
      src_sel = 1'b0;
    cap_fire = CLK_EN && cap_en && src_sel && !src_prev_r;  // [R21]
  end

  // Edge history; a held source captures only once
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      src_prev_r <= 1'b0;
    else if (CLK_EN)
      src_prev_r <= src_sel;
  end

  // Capture register; the counter keeps running
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      capture_r <= CAPTURE_RST;
    else if (cap_fire)
      capture_r <= count_r[15:0];  // [R15]
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 32'h00000000;
    end else if (CLK_EN) begin
      RDATA <= 32'h00000000;
      if (RD) begin
        if (ADDR == LOAD_OFS)
          RDATA <= load_r;
        else if (ADDR == VAL_LOW_OFS)
          RDATA <= {16'h0000, count_r[15:0]};  // [R3]
        else if (ADDR == VAL_HIGH_OFS)
          RDATA <= count_r[47:16];  // [R3] [R13]
        else if (ADDR == CONTROL_OFS)
          RDATA <= {14'h0000, control_r};
        else if (ADDR == CAPTURE_OFS)
          RDATA <= {16'h0000, capture_r};
      end
    end
  end

  // Checks
  sequence s_src_rise;
    CLK_EN && cap_en && src_sel && !src_prev_r;
  endsequence

  sequence s_src_held;
    CLK_EN && src_sel && $stable(evt_code) && $stable(cap_en);
  endsequence

  a_clear_drops_irq: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_clear && !term_evt |=> !TIMER_IRQ)  // [R6]
    else $error("clear write left interrupt set");

  a_irq_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    term_evt || (TIMER_IRQ && !wr_clear) |=> TIMER_IRQ)  // [R22]
    else $error("interrupt dropped without a clear write");

  a_free_down_wrap: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    term_evt && is16(fmt) && !count_up && !periodic && !WR
    |=> count_r == 48'h00000000FFFF && TIMER_IRQ)  // [R1]
    else $error("free-running down count did not wrap to max");

  a_periodic_reload: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    term_evt && is16(fmt) && periodic && !WR
    |=> count_r[15:0] == $past(load_r[15:0]))  // [R2]
    else $error("periodic count did not restart from load");

  a_clear_reload: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_clear && is16(fmt) |=> count_r[15:0] == $past(load_r[15:0]))  // [R16]
    else $error("clear write did not reload the counter");

  a_start_on_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_ctrl && WDATA[ENABLE_BIT] && !enabled
    |=> enabled && (fmt != FMT_BIN48 || count_r == 48'h000000000000))  // [R4] [R13]
    else $error("control write did not start the timer");

  a_capture_copy: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    s_src_rise |=> capture_r == $past(count_r[15:0]))  // [R15]
    else $error("capture did not copy the count");

  a_one_capture: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    s_src_rise ##1 s_src_held |-> !cap_fire)  // [R21]
    else $error("held source captured twice");

  a_read_value: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    CLK_EN && RD && ADDR == VAL_LOW_OFS |=> RDATA == {16'h0000, $past(count_r[15:0])})  // [R3]
    else $error("value read returned wrong count");

  a_count_frozen: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !CLK_EN |=> $stable(count_r) && $stable(TIMER_IRQ))
    else $error("state moved with clock enable low");

endmodule : lifetime_timer

// ---- design/lifetime_timer_pkg.sv ----
package lifetime_timer_pkg;

  // Register byte offsets
  localparam logic [7:0] LOAD_OFS     = 8'h00;  // Load value, read/write
  localparam logic [7:0] VAL_LOW_OFS  = 8'h04;  // Count bits 15:0, read only
  localparam logic [7:0] VAL_HIGH_OFS = 8'h08;  // Count bits 47:16, read only
  localparam logic [7:0] CONTROL_OFS  = 8'h0C;  // Control, read/write
  localparam logic [7:0] CLEAR_OFS    = 8'h10;  // Interrupt clear, write only
  localparam logic [7:0] CAPTURE_OFS  = 8'h14;  // Captured count, read only

  // Control field positions
  localparam int PRESCALE_LSB = 0;   // Prescaler code 3:0
  localparam int FORMAT_LSB   = 4;   // Format field 5:4
  localparam int PERIODIC_BIT = 6;   // Periodic mode
  localparam int ENABLE_BIT   = 7;   // Timer enable
  localparam int COUNT_UP_BIT = 8;   // Count direction
  localparam int CLK_SEL_LSB  = 9;   // Clock select 10:9
  localparam int EVENT_LSB    = 12;  // Capture event code 16:12
  localparam int CAP_EN_BIT   = 17;  // Capture enable
  localparam int CONTROL_W    = 18;  // Implemented control width

  // Reset values
  localparam logic [CONTROL_W-1:0] CONTROL_RST = 18'h00000;
  localparam logic [31:0]          LOAD_RST    = 32'h00000000;
  localparam logic [47:0]          COUNT_RST   = 48'h000000000000;
  localparam logic [15:0]          CAPTURE_RST = 16'h0000;

  // Format codes in control 5:4
  localparam logic [1:0] FMT_BIN16 = 2'h0;  // 16-bit up/down
  localparam logic [1:0] FMT_BIN48 = 2'h1;  // 48-bit up from zero
  localparam logic [1:0] FMT_ALT16 = 2'h2;  // Treated as 16-bit
  localparam logic [1:0] FMT_HMS   = 2'h3;  // Hours:minutes:seconds:1/128

  // Clock source codes
  localparam logic [1:0] CLK_OSC32  = 2'h0;  // Internal 32 kHz oscillator
  localparam logic [1:0] CLK_UNDIV  = 2'h1;  // Undivided PLL clock
  localparam logic [1:0] CLK_XTAL32 = 2'h2;  // External 32 kHz crystal
  localparam logic [1:0] CLK_CORE   = 2'h3;  // Core clock

  // Prescaler codes and their terminal counts (divisor minus one)
  localparam logic [3:0]  PRE_DIV1      = 4'h0;
  localparam logic [3:0]  PRE_DIV16     = 4'h4;
  localparam logic [3:0]  PRE_DIV256    = 4'h8;
  localparam logic [3:0]  PRE_DIV32768  = 4'hF;
  localparam logic [14:0] LIM_DIV1      = 15'h0000;
  localparam logic [14:0] LIM_DIV16     = 15'h000F;
  localparam logic [14:0] LIM_DIV256    = 15'h00FF;
  localparam logic [14:0] LIM_DIV32768  = 15'h7FFF;

  // Capture event codes
  localparam logic [4:0] EVT_SELF      = 5'h00;  // The lifetime timer itself
  localparam logic [4:0] EVT_CONVERTER = 5'h0A;  // Converter
  localparam logic [4:0] EVT_EXT_IRQ0  = 5'h11;  // External interrupt pin zero
  localparam int         EVT_COUNT     = 18;     // Codes 0 to 17

  // Time-of-day field limits and layout mask
  localparam logic [6:0]  HMS_SUB_MAX = 7'h7F;
  localparam logic [5:0]  HMS_SEC_MAX = 6'h3B;
  localparam logic [7:0]  HMS_HR_MAX  = 8'hFF;
  localparam logic [31:0] HMS_MASK    = 32'hFF3F3F7F;
  localparam logic [31:0] HMS_FULL    = 32'hFF3B3B7F;

endpackage : lifetime_timer_pkg

// ---- design/lifetime_tick_gen.sv ----
`timescale 1ns/10ps
module lifetime_tick_gen
  import lifetime_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic [3:0] prescale,
  input  wire logic       osc_in,
  input  wire logic       xtal_in,
  input  wire logic       undiv_in,
  output logic            tick
);

  logic [2:0]  osc_s_r;    // Synchroniser plus edge history
  logic [2:0]  xtal_s_r;
  logic [2:0]  undiv_s_r;
  logic        src_pulse;  // One pulse per source clock rising edge
  logic [14:0] div_r;      // Prescaler count
  logic [14:0] div_lim;    // Terminal count of the prescaler

  function automatic logic [14:0] prescale_limit(input logic [3:0] code);
    // Undocumented codes fall back to divide-by-1
    if (code == PRE_DIV16)
      return LIM_DIV16;
    else if (code == PRE_DIV256)
      return LIM_DIV256;
    else if (code == PRE_DIV32768)
      return LIM_DIV32768;
    else
      return LIM_DIV1;
  endfunction : prescale_limit

  // Two flops before any logic; stage 0 is read only by stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s_r   <= 3'h0;
      xtal_s_r  <= 3'h0;
      undiv_s_r <= 3'h0;
    end else if (ce) begin
      osc_s_r   <= {osc_s_r[1:0], osc_in};
      xtal_s_r  <= {xtal_s_r[1:0], xtal_in};
      undiv_s_r <= {undiv_s_r[1:0], undiv_in};
    end
  end

  // Source select, edge found between stages 1 and 2
  always_comb begin
    div_lim = prescale_limit(prescale);  // [R19]
    case (clk_sel)  // [R12] [R18]
      CLK_OSC32:  src_pulse = osc_s_r[1] & ~osc_s_r[2];
      CLK_UNDIV:  src_pulse = undiv_s_r[1] & ~undiv_s_r[2];
      CLK_XTAL32: src_pulse = xtal_s_r[1] & ~xtal_s_r[2];
      default:    src_pulse = 1'b1;
    endcase
  end

  // Prescaler; restarts whenever the timer is stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 15'h0000;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        div_r <= 15'h0000;
      end else if (src_pulse) begin
        if (div_r >= div_lim) begin  // [R8]
          div_r <= 15'h0000;
          tick  <= 1'b1;
        end else begin
          div_r <= div_r + 15'h0001;
        end
      end
    end
  end

endmodule : lifetime_tick_gen

// ---- verification/irq_source_model.sv ----
`timescale 1ns/10ps
// Stand-in for the on-chip interrupt sources seen by the capture logic
module irq_source_model (
  input  wire logic        clk,     // Core clock
  input  wire logic        rst_n,   // Async reset, active low
  input  wire logic        req,     // Change one source level
  input  wire logic [4:0]  idx,     // Source code, 1 to 17
  input  wire logic        lvl,     // New level for that source
  output logic      [17:1] srcs     // Interrupt levels to the timer
);
  // Registered levels, as real sources are; a new rise needs a low cycle first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcs <= 17'h00000;
    end else if (req && idx >= 5'h01 && idx <= 5'h11) begin
      srcs[idx] <= lvl;
    end
  end
endmodule : irq_source_model

// ---- verification/lifetime_timer_tb_top.sv ----
`timescale 1ns/10ps
module lifetime_timer_tb_top;
  import lifetime_timer_pkg::*;
  logic        clk, rst_n, clk_en;   // Clock, reset, enable
  logic [7:0]  addr;                 // Bus address
  logic [31:0] wdata, rdata, got;    // Bus data and last read
  logic        wr, rd, timer_irq;    // Strobes and interrupt
  logic [17:1] irq_src;              // Source levels
  logic        osc, xtal, undiv;     // Slow clock pins
  logic        req, req_lvl;         // Partner request
  logic [4:0]  req_idx;              // Partner source code
  logic [31:0] seed;                 // Random state
  logic [15:0] start;                // Wrap test start value
  int          n_mismatch, total_checks;
  logic [3:0]  pres [3] = '{PRE_DIV1, PRE_DIV16, PRE_DIV256};
  int          divs [3] = '{1, 16, 256};

  lifetime_timer dut_u (.CORE_CLK(clk), .RESETN(rst_n), .CLK_EN(clk_en), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_SOURCES(irq_src),
    .OSC32K_IN(osc), .XTAL32K_IN(xtal), .UNDIVIDED_PLL_CLOCK(undiv), .TIMER_IRQ(timer_irq));
  irq_source_model src_u (.clk(clk), .rst_n(rst_n), .req(req), .idx(req_idx), .lvl(req_lvl),
    .srcs(irq_src));

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Random source, fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  // Control word assembled from its fields
  function automatic logic [31:0] ctl(input logic [1:0] fmt, input logic per, en, up,
                                      input logic [1:0] sel, input logic [3:0] pre,
                                      input logic cap, input logic [4:0] evt);
    return {14'h0000, cap, evt, 1'b0, sel, up, en, per, fmt, pre};
  endfunction : ctl

  // Count after n ticks, wrapping as free-running or periodic
  function automatic logic [15:0] step16(input logic [15:0] v, input logic up, per,
                                         input logic [15:0] ld, input int n);
    for (int i = 0; i < n; i++) begin
      if (up) v = (v == 16'hFFFF) ? (per ? ld : 16'h0000) : v + 16'h0001;
      else v = (v == 16'h0000) ? (per ? ld : 16'hFFFF) : v - 16'h0001;
    end
    return v;
  endfunction : step16

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic check_in(input string name, input logic [31:0] lo, hi, seen);
    total_checks++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("mismatch %s expected %h to %h seen %h", name, lo, hi, seen);
    end
  endtask : check_in

  // One-cycle write strobe; a gap cycle follows
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_wr

  // Data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : bus_rd

  // Rising edges on a slow pin, slow enough for the two-flop sync
  task automatic pulse(input logic [1:0] sel, input int n);
    repeat (n) begin
      @(posedge clk);
      case (sel)
        CLK_OSC32: osc   <= 1'b1;
        CLK_UNDIV: undiv <= 1'b1;
        default:   xtal  <= 1'b1;
      endcase
      repeat (3) @(posedge clk);
      osc   <= 1'b0;
      undiv <= 1'b0;
      xtal  <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pulse

  task automatic src_set(input logic [4:0] c, input logic l);
    @(posedge clk);
    req     <= 1'b1;
    req_idx <= c;
    req_lvl <= l;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : src_set

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog, well beyond the roughly 14k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {rst_n, addr, wdata, wr, rd, osc, xtal, undiv, req, req_idx, req_lvl} = '0;
    clk_en = 1'b1;
    seed = 32'h7C9B9477;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Read-only places ignore writes; all reads zero after reset
    bus_wr(VAL_LOW_OFS, 32'h0000ABCD);
    bus_wr(CAPTURE_OFS, 32'h00001234);
    for (int a = 0; a < 7; a++) begin
      bus_rd(8'(a * 4), got);
      check("reset", 32'h00000000, got);
    end
    // Control fields read back, enable kept low
    repeat (4) begin
      seed = lfsr(seed);
      bus_wr(CONTROL_OFS, seed & 32'h0003F77F);
      bus_rd(CONTROL_OFS, got);
      check("control", seed & 32'h0003F77F, got);
    end
    bus_wr(CONTROL_OFS, 32'h00000000);
    // Bus frozen while the clock enable is low
    @(posedge clk);
    clk_en <= 1'b0;
    bus_wr(LOAD_OFS, 32'h00001234);
    clk_en <= 1'b1;
    bus_rd(LOAD_OFS, got);
    check("frozen load", 32'h00000000, got);
    // 16-bit load value goes straight into the counter
    repeat (3) begin
      seed = lfsr(seed);
      bus_wr(LOAD_OFS, {16'h0000, seed[15:0]});
      bus_rd(VAL_LOW_OFS, got);
      check("load to count", {16'h0000, seed[15:0]}, got);
    end
    // Each slow clock pin with prescalers 1, 16 and 256; counting stops when disabled
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 3; p++) begin
        bus_wr(CONTROL_OFS, ctl(FMT_BIN16, 1'b0, 1'b1, 1'b1, 2'(s), pres[p], 1'b0, 5'h00));
        pulse(2'(s), divs[p] - 1);
        bus_rd(VAL_LOW_OFS, got);
        check("prescale hold", 32'h00000000, got);
        pulse(2'(s), 1);
        bus_rd(VAL_LOW_OFS, got);
        check("prescale step", 32'h00000001, got);
        bus_wr(CONTROL_OFS, ctl(FMT_BIN16, 1'b0, 1'b0, 1'b1, 2'(s), pres[p], 1'b0, 5'h00));
        pulse(2'(s), divs[p]);
        bus_rd(VAL_LOW_OFS, got);
        check("disabled", 32'h00000001, got);
      end
    end
    // Wrap in both directions, free-running and periodic, then clear
    for (int m = 0; m < 4; m++) begin
      start = m[0] ? 16'hFFFD : 16'h0002;
      bus_wr(CONTROL_OFS, ctl(FMT_BIN16, m[1], 1'b1, m[0], CLK_OSC32, PRE_DIV1, 1'b0, 5'h00));
      bus_wr(LOAD_OFS, {16'h0000, start});
      pulse(CLK_OSC32, 4);
      bus_rd(VAL_LOW_OFS, got);
      check("wrap", {16'h0000, step16(start, m[0], m[1], start, 4)}, got);
      check("irq set", 32'h00000001, {31'h0, timer_irq});
      seed = lfsr(seed);
      bus_wr(CLEAR_OFS, seed);
      @(negedge clk);
      check("irq clear", 32'h00000000, {31'h0, timer_irq});
      bus_rd(VAL_LOW_OFS, got);
      check("clear reload", {16'h0000, start}, got);
    end
    // Core clock, periodic down from 5, own interrupt as capture source
    bus_wr(CONTROL_OFS, 32'h00000000);
    bus_wr(LOAD_OFS, 32'h00000005);
    bus_wr(CONTROL_OFS, ctl(FMT_BIN16, 1'b1, 1'b1, 1'b0, CLK_CORE, PRE_DIV1, 1'b1, EVT_SELF));
    for (int i = 0; i < 40 && timer_irq !== 1'b1; i++) @(negedge clk);
    check("core irq", 32'h00000001, {31'h0, timer_irq});
    repeat (20) @(posedge clk);
    check("irq sticky", 32'h00000001, {31'h0, timer_irq});
    repeat (6) begin
      bus_rd(VAL_LOW_OFS, got);
      check_in("periodic run", 32'h0, 32'h5, got);
    end
    bus_rd(CAPTURE_OFS, got);
    check_in("self capture", 32'h0, 32'h5, got);
    // Slowest prescaler keeps the free-running seed in view
    bus_wr(CONTROL_OFS, 32'h00000000);
    bus_wr(CONTROL_OFS, ctl(FMT_BIN16, 1'b0, 1'b1, 1'b0, CLK_CORE, PRE_DIV32768, 1'b0, 5'h00));
    repeat (2) begin
      bus_rd(VAL_LOW_OFS, got);
      check("free seed", 32'h0000FFFF, got);
    end
    // 48-bit mode starts from zero whatever the counter held
    bus_wr(CONTROL_OFS, 32'h00000000);
    bus_wr(LOAD_OFS, 32'h0000FFFF);
    bus_wr(CONTROL_OFS, ctl(FMT_BIN48, 1'b0, 1'b1, 1'b0, CLK_OSC32, PRE_DIV1, 1'b0, 5'h00));
    pulse(CLK_OSC32, 3);
    bus_rd(VAL_LOW_OFS, got);
    check("wide low", 32'h00000003, got);
    bus_rd(VAL_HIGH_OFS, got);
    check("wide high", 32'h00000000, got);
    // Time of day: 05:00:59:126 plus two 1/128 steps rolls the minute
    bus_wr(CONTROL_OFS, 32'h00000000);
    bus_wr(LOAD_OFS, 32'h05003B7E);
    bus_wr(CONTROL_OFS,
           ctl(FMT_HMS, 1'b1, 1'b1, 1'b1, CLK_OSC32, PRE_DIV256, 1'b0, 5'h00));
    pulse(CLK_OSC32, 512);
    bus_rd(VAL_LOW_OFS, got);
    check("tod low", 32'h00000000, got);
    bus_rd(VAL_HIGH_OFS, got);
    check("tod high", 32'h00000501, got);
    bus_rd(LOAD_OFS, got);
    check("tod load", 32'h05003B7E, got);
    // Event codes 1 to 17; a held source captures only once
    for (int c = 1; c < 18; c++) begin
      seed = lfsr(seed);
      bus_wr(CONTROL_OFS, ctl(FMT_BIN16, 1'b0, 1'b0, 1'b0, CLK_CORE, PRE_DIV1, 1'b1, 5'(c)));
      bus_wr(LOAD_OFS, {16'h0000, seed[15:0]});
      src_set(5'(c), 1'b1);
      bus_wr(LOAD_OFS, {16'h0000, seed[31:16]});
      bus_rd(CAPTURE_OFS, got);
      check("capture held", {16'h0000, seed[15:0]}, got);
      src_set(5'(c), 1'b0);
      src_set(5'(c), 1'b1);
      bus_rd(CAPTURE_OFS, got);
      check("capture again", {16'h0000, seed[31:16]}, got);
      src_set(5'(c), 1'b0);
    end
    end_of_test();
  end
endmodule : lifetime_timer_tb_top
